// File: rtl/hph_handshake.sv
// Handshake logic of the 16-bit host port: strobe, select capture, data drive, ready.
// Assumes the memory side supplies read words, fetch completion and transfer completion.
`timescale 1ns/1ps
`default_nettype none
module hph_handshake (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Host pins
  input wire logic port_select_n,
  input wire logic data_strobe_one,
  input wire logic data_strobe_two,
  input wire logic address_strobe_n,
  input wire logic [1:0] access_type_select,
  input wire logic read_write_select,
  input wire logic halfword_select,
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic port_ready_n,
  // Memory side
  input wire logic [15:0] rd_word,
  input wire logic fetch_loaded,
  input wire logic xfer_done,
  output logic fetch_req,
  output logic xfer_req,
  output logic wr_strobe,
  output logic [15:0] wr_data,
  output logic [1:0] cur_access_type,
  output logic cur_read,
  output logic cur_halfword
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins

  hph_sync_if pins ();

  logic comb_strobe;
  assign comb_strobe = ~(data_strobe_one ^ data_strobe_two) | port_select_n; // RULE_01
  assign pins.raw = {host_data_bus_in, halfword_select, read_write_select,
                     access_type_select, address_strobe_n, port_select_n, comb_strobe};

  hph_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pins(pins)
  );

  logic stb_s;
  logic cs_s;
  logic as_s;
  logic [1:0] acc_s;
  logic rw_s;
  logic hw_s;
  logic [15:0] data_s;
  assign stb_s = pins.sync[hph_pkg::POS_STB];
  assign cs_s = pins.sync[hph_pkg::POS_CS];
  assign as_s = pins.sync[hph_pkg::POS_AS];
  assign acc_s = pins.sync[hph_pkg::POS_ACC +: 2];
  assign rw_s = pins.sync[hph_pkg::POS_RW];
  assign hw_s = pins.sync[hph_pkg::POS_HW];
  assign data_s = pins.sync[hph_pkg::POS_DATA +: hph_pkg::DATA_W];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic stb_q_ff;
  logic as_q_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stb_q_ff <= 1'b1;
      as_q_ff <= 1'b1;
    end else begin
      stb_q_ff <= stb_s;
      as_q_ff <= as_s;
    end
  end

  logic stb_fall;
  logic stb_rise;
  logic as_fall;
  assign stb_fall = stb_q_ff & ~stb_s;
  assign stb_rise = ~stb_q_ff & stb_s;
  assign as_fall = as_q_ff & ~as_s;

  ////////////////////////////////////////////////////////////////////////////
  // Select capture; the address strobe, when used, takes precedence

  logic [1:0] acc_ff;
  logic rw_ff;
  logic hw_ff;
  logic as_held_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= hph_pkg::ACC_CTRL;
      rw_ff <= 1'b1;
      hw_ff <= 1'b0;
      as_held_ff <= 1'b0;
    end else begin
      if (as_fall || (stb_fall && !as_held_ff)) begin
        acc_ff <= acc_s; // RULE_08
        rw_ff <= rw_s; // RULE_08
        hw_ff <= hw_s; // RULE_08
      end
      if (as_fall) begin
        as_held_ff <= 1'b1;
      end else if (stb_rise) begin
        as_held_ff <= 1'b0;
      end
    end
  end

  // Selects in force at the strobe fall, before the latch has updated
  logic [1:0] acc_eff;
  logic rw_eff;
  logic hw_eff;
  assign acc_eff = as_held_ff ? acc_ff : acc_s;
  assign rw_eff = as_held_ff ? rw_ff : rw_s;
  assign hw_eff = as_held_ff ? hw_ff : hw_s;

  logic is_data;
  assign is_data = (acc_eff == hph_pkg::ACC_DATA) || (acc_eff == hph_pkg::ACC_DATA_INC);

  ////////////////////////////////////////////////////////////////////////////
  // Data read fetch from the auxiliary channel

  logic fetch_start;
  assign fetch_start = stb_fall && rw_eff && is_data && !hw_eff;

  logic fetch_wait_ff;
  logic fetch_req_ff;
  logic [1:0] settle_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetch_wait_ff <= 1'b0;
      fetch_req_ff <= 1'b0;
    end else begin
      fetch_req_ff <= fetch_start; // RULE_04
      if (fetch_start) begin
        fetch_wait_ff <= 1'b1; // RULE_04
      end else if (fetch_loaded) begin
        fetch_wait_ff <= 1'b0;
      end
    end
  end

  // Lag beyond the one clock that the ready flop already adds after the data load
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settle_ff <= 2'h0;
    end else if (fetch_loaded && fetch_wait_ff) begin
      settle_ff <= hph_pkg::READY_LAG_CYC; // RULE_12
    end else if (settle_ff != 2'h0) begin
      settle_ff <= settle_ff - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data drive

  logic [15:0] dout_ff;
  logic oe_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dout_ff <= hph_pkg::DATA_RST;
    end else if ((stb_fall && rw_eff && !fetch_start) || (fetch_loaded && fetch_wait_ff)) begin
      dout_ff <= rd_word; // RULE_11
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oe_ff <= 1'b0;
    end else if (stb_rise || cs_s) begin
      oe_ff <= 1'b0; // RULE_11
    end else if (stb_fall && rw_eff) begin
      oe_ff <= 1'b1; // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write capture and internal transfer

  logic wr_strobe_ff;
  logic [15:0] wr_data_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_strobe_ff <= 1'b0;
      wr_data_ff <= hph_pkg::DATA_RST;
    end else begin
      wr_strobe_ff <= stb_rise && !rw_ff; // RULE_13
      if (stb_rise && !rw_ff) begin
        wr_data_ff <= data_s; // RULE_13
      end
    end
  end

  logic xfer_start;
  assign xfer_start = stb_rise && hw_ff &&
    ((!rw_ff && (acc_ff == hph_pkg::ACC_DATA || acc_ff == hph_pkg::ACC_DATA_INC)) ||
     (rw_ff && acc_ff == hph_pkg::ACC_DATA_INC));

  logic busy_ff;
  logic xfer_req_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      xfer_req_ff <= 1'b0;
    end else begin
      xfer_req_ff <= xfer_start; // RULE_05
      // A completion in the same cycle as a new start leaves busy set
      if (xfer_start) begin
        busy_ff <= 1'b1; // RULE_05
      end else if (xfer_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready; fetch_start is included so ready never dips at the strobe fall

  logic ready_n_ff;
  logic nxt_ready_n;
  always_comb begin
    if (cs_s) begin
      nxt_ready_n = 1'b0; // RULE_02
    end else begin
      nxt_ready_n = busy_ff || fetch_wait_ff || fetch_start || (settle_ff > 2'h1); // RULE_03 RULE_06
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready_n_ff <= 1'b0;
    end else begin
      ready_n_ff <= nxt_ready_n;
    end
  end

  assign port_ready_n = ready_n_ff;
  assign host_data_bus_out = dout_ff;
  assign host_data_bus_oe = oe_ff;
  assign fetch_req = fetch_req_ff;
  assign xfer_req = xfer_req_ff;
  assign wr_strobe = wr_strobe_ff;
  assign wr_data = wr_data_ff;
  assign cur_access_type = acc_ff;
  assign cur_read = rw_ff;
  assign cur_halfword = hw_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_strobe_sync;
    @(posedge clk_sys) disable iff (!reset_n)
    ##2 stb_s == $past(comb_strobe, 2);
  endproperty
  a_strobe_sync: assert property (p_strobe_sync) else $error("strobe sync mismatch"); // RULE_01 RULE_14

  property p_cs_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    cs_s |=> !port_ready_n;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("ready high while deselected"); // RULE_02

  property p_busy_ready;
    @(posedge clk_sys) disable iff (!reset_n)
    busy_ff && !cs_s |=> port_ready_n;
  endproperty
  a_busy_ready: assert property (p_busy_ready) else $error("ready low while busy"); // RULE_03

  property p_fetch;
    @(posedge clk_sys) disable iff (!reset_n)
    fetch_start && !cs_s |=> fetch_req && fetch_wait_ff && port_ready_n;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not requested"); // RULE_04

  property p_xfer;
    @(posedge clk_sys) disable iff (!reset_n)
    xfer_start |=> xfer_req && busy_ff ##1 !xfer_req;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer not started"); // RULE_05

  property p_quiet;
    @(posedge clk_sys) disable iff (!reset_n)
    !busy_ff && !fetch_wait_ff && !fetch_start && settle_ff == 2'h0 |=> !port_ready_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("ready raised without cause"); // RULE_06

  property p_select_latch;
    @(posedge clk_sys) disable iff (!reset_n)
    stb_fall && !as_held_ff && !as_fall |=> acc_ff == $past(acc_s) && rw_ff == $past(rw_s);
  endproperty
  a_select_latch: assert property (p_select_latch) else $error("selects not latched"); // RULE_08

  property p_oe_off;
    @(posedge clk_sys) disable iff (!reset_n)
    stb_rise |=> !host_data_bus_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven after strobe rise"); // RULE_11

  property p_settle;
    @(posedge clk_sys) disable iff (!reset_n)
    fetch_loaded && fetch_wait_ff && !cs_s ##1 !cs_s
      |-> host_data_bus_out == $past(rd_word) && port_ready_n;
  endproperty
  a_settle: assert property (p_settle) else $error("ready before data settled"); // RULE_12

  // Data reaches the pins one clock after the load; ready follows one clock later
  property p_ready_lag;
    @(posedge clk_sys) disable iff (!reset_n)
    fetch_loaded && fetch_wait_ff && !fetch_start && !busy_ff && !cs_s
      ##1 !cs_s && !busy_ff && !fetch_start |=> !port_ready_n;
  endproperty
  a_ready_lag: assert property (p_ready_lag) else $error("ready late after read data"); // RULE_12

  property p_wr_cap;
    @(posedge clk_sys) disable iff (!reset_n)
    stb_rise && !rw_ff |=> wr_strobe && wr_data == $past(data_s);
  endproperty
  a_wr_cap: assert property (p_wr_cap) else $error("write data not captured"); // RULE_13

endmodule // hph_handshake
`default_nettype wire

// File: rtl/hph_pkg.sv
// Constants shared by the host port handshake block.
// Assumes a single 20 MHz system clock and host pins that arrive unsynchronised.
//
// How it works
// RULE_01: Strobe is NOT(strobe XOR) OR select.
// RULE_02: Ready held low while port deselected.
// RULE_03: Ready high on select while transfer finishes.
// RULE_04: Data read fetches word, ready high meanwhile.
// RULE_05: Second half-word rise starts transfer, ready high.
// RULE_06: Other accesses never raise ready.
// RULE_07: Host holds strobe until ready low.
// RULE_08: Selects latched at strobe or address-strobe fall.
// RULE_09: Address strobe optional, low across strobe fall.
// RULE_10: Strobe low and high two clocks minimum.
// RULE_11: Read drivers on after fall, off after rise.
// RULE_12: Ready falls one clock after read data.
// RULE_13: Write data captured at strobe rise.
// RULE_14: Host strobes pass two synchroniser stages.
package hph_pkg;

  // Access type codes on the select pair
  localparam logic [1:0] ACC_CTRL = 2'h0;
  localparam logic [1:0] ACC_DATA_INC = 2'h1;
  localparam logic [1:0] ACC_ADDR = 2'h2;
  localparam logic [1:0] ACC_DATA = 2'h3;

  // Layout of the vector that crosses the synchroniser
  localparam int SYNC_W = 23;
  localparam int POS_STB = 0;
  localparam int POS_CS = 1;
  localparam int POS_AS = 2;
  localparam int POS_ACC = 3;
  localparam int POS_RW = 5;
  localparam int POS_HW = 6;
  localparam int POS_DATA = 7;
  localparam int DATA_W = 16;

  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = 23'h000007;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Ready lags read data by about one clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int READY_LAG_NS = 50;
  localparam logic [1:0] READY_LAG_CYC =
    2'((READY_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// File: rtl/hph_sync_if.sv
// Carries the raw host pin vector to the synchroniser and the clean copy back.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface hph_sync_if;
  logic [hph_pkg::SYNC_W-1:0] raw;
  logic [hph_pkg::SYNC_W-1:0] sync;
  modport stage (input raw, output sync);
  modport user (output raw, input sync);
endinterface // hph_sync_if
`default_nettype wire

// File: rtl/hph_sync.sv
// Two-stage synchroniser, one chain per bit of the host pin vector.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module hph_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pin vector
  hph_sync_if.stage pins
);

  logic [hph_pkg::SYNC_W-1:0] meta_ff;
  logic [hph_pkg::SYNC_W-1:0] sync_ff;

  // First stage is read only by the second
  for (genvar i = 0; i < hph_pkg::SYNC_W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        meta_ff[i] <= hph_pkg::SYNC_RST[i];
        sync_ff[i] <= hph_pkg::SYNC_RST[i];
      end else begin
        meta_ff[i] <= pins.raw[i]; // RULE_14
        sync_ff[i] <= meta_ff[i]; // RULE_14
      end
    end
  end

  assign pins.sync = sync_ff;

endmodule // hph_sync
`default_nettype wire

// File: bench/hph_host_model.sv
// Host processor model for the host port: drives strobes, selects and write data.
// Assumes the bench calls acc once at a time and feeds back the device outputs.
`timescale 1ns/1ps
`default_nettype none
module hph_host_model (
  // Clock
  input wire logic clk_sys,
  // Host pins
  output logic port_select_n,
  output logic data_strobe_one,
  output logic data_strobe_two,
  output logic address_strobe_n,
  output logic [1:0] access_type_select,
  output logic read_write_select,
  output logic halfword_select,
  output logic [15:0] host_data_bus_in,
  // Device answers
  input wire logic [15:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  input wire logic port_ready_n
);
  logic [15:0] drv = 16'h0000;
  logic drv_en = 1'b0;
  initial begin
    port_select_n = 1'b1;
    data_strobe_one = 1'b0;
    data_strobe_two = 1'b0;
    address_strobe_n = 1'b1;
    access_type_select = 2'h0;
    read_write_select = 1'b0;
    halfword_select = 1'b0;
  end
  // Undriven bus shows the inverse of the last word, never a stale copy
  always_comb host_data_bus_in = host_data_bus_oe ? host_data_bus_out : (drv_en ? drv : ~drv);
  task automatic acc(input logic [1:0] t, input logic rd, input logic hw, input logic [15:0] d,
                     input logic use_as, output logic [15:0] q, output logic ok);
    int i;
    i = 0;
    @(posedge clk_sys);
    port_select_n <= 1'b0;
    access_type_select <= t;
    read_write_select <= rd;
    halfword_select <= hw;
    drv <= d;
    drv_en <= !rd;
    if (use_as) begin
      @(posedge clk_sys);
      address_strobe_n <= 1'b0;
    end
    @(posedge clk_sys);
    if (use_as) access_type_select <= ~t;
    if (use_as) data_strobe_two <= 1'b1;
    else data_strobe_one <= 1'b1;
    repeat (4) @(posedge clk_sys);
    while (port_ready_n !== 1'b0 && i < 300) begin
      @(posedge clk_sys);
      i++;
    end
    ok = (i < 300);
    q = host_data_bus_in;
    data_strobe_one <= 1'b0;
    data_strobe_two <= 1'b0;
    address_strobe_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    drv_en <= 1'b0;
    port_select_n <= 1'b1;
  endtask
endmodule // hph_host_model
`default_nettype wire

// File: bench/tb_host_port_handshake.sv
// Self-checking bench for the host port handshake block.
// Assumes the host model and a memory-side responder written here.
`timescale 1ns/1ps
`default_nettype none
module tb_host_port_handshake;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, ds1, ds2, as_n, rw, hw, oe, rdy_n, fetch_req, xfer_req, wr_strobe, cur_read, cur_hw;
  logic [1:0] acc_t, cur_t;
  logic [15:0] din, dout, wr_data;
  logic [15:0] word = 16'hc35a;
  logic fetch_loaded = 1'b0;
  logic xfer_done = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int fdly = 3, xdly = 3, fc = 0, xc = 0, n_fetch = 0, n_xfer = 0, cs_hi = 0;
  logic busy_seen = 1'b0;
  always #25 clk_sys = ~clk_sys;
  hph_handshake i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .port_select_n(cs_n),
    .data_strobe_one(ds1), .data_strobe_two(ds2), .address_strobe_n(as_n),
    .access_type_select(acc_t), .read_write_select(rw), .halfword_select(hw),
    .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe(oe),
    .port_ready_n(rdy_n), .rd_word(word), .fetch_loaded(fetch_loaded), .xfer_done(xfer_done),
    .fetch_req(fetch_req), .xfer_req(xfer_req), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .cur_access_type(cur_t), .cur_read(cur_read), .cur_halfword(cur_hw));
  hph_host_model i_host (.clk_sys(clk_sys), .port_select_n(cs_n), .data_strobe_one(ds1),
    .data_strobe_two(ds2), .address_strobe_n(as_n), .access_type_select(acc_t),
    .read_write_select(rw), .halfword_select(hw), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe(oe), .port_ready_n(rdy_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Memory side answers after a chosen delay; monitors count requests
  always @(posedge clk_sys) begin
    fetch_loaded <= (fc == 1);
    xfer_done <= (xc == 1);
    fc <= fetch_req ? fdly : (fc > 0 ? fc - 1 : 0);
    xc <= xfer_req ? xdly : (xc > 0 ? xc - 1 : 0);
    n_fetch <= n_fetch + int'(fetch_req === 1'b1);
    n_xfer <= n_xfer + int'(xfer_req === 1'b1);
    if (rdy_n === 1'b1) busy_seen <= 1'b1;
    cs_hi <= cs_n ? cs_hi + 1 : 0;
    if (cs_hi > 3) chk("ready_desel", 16'(rdy_n), 16'h0000);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic a(input logic [1:0] t, input logic r, input logic h, input logic [15:0] d,
                   input logic s, output logic [15:0] q);
    logic ok;
    i_host.acc(t, r, h, d, s, q, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR ready_wait expected 0 seen 1");
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Control and address accesses: selects latched, write word captured, never busy
  task automatic t_plain();
    logic [15:0] q;
    logic [1:0] tt;
    busy_seen = 1'b0;
    for (int k = 0; k < 8; k++) begin
      tt = k[2] ? hph_pkg::ACC_ADDR : hph_pkg::ACC_CTRL;
      a(tt, k[0], k[1], 16'h1200 + 16'(k), 1'b0, q);
      chk("cur_type", 16'(cur_t), 16'(tt));
      chk("cur_read", 16'(cur_read), 16'(k[0]));
      chk("cur_half", 16'(cur_hw), 16'(k[1]));
      if (!k[0]) chk("wr_data", wr_data, 16'h1200 + 16'(k));
      if (k[0]) chk("plain_rd", q, 16'hc35a);
      chk("oe_off", 16'(oe), 16'h0000);
    end
    chk("plain_busy", 16'(busy_seen), 16'h0000);
  endtask
  // Fixed and incrementing data read: first half fetches and is busy, second half transfers and is busy only when incrementing
  task automatic t_data_read(input logic [1:0] tt);
    logic [15:0] q;
    int f0;
    int x0;
    fdly = 12;
    word = 16'h3c00 + 16'(tt);
    f0 = n_fetch;
    x0 = n_xfer;
    busy_seen = 1'b0;
    a(tt, 1'b1, 1'b0, word, 1'b0, q);
    chk("read_word", q, word);
    chk("fetch_cnt", 16'(n_fetch - f0), 16'h0001);
    chk("fetch_busy", 16'(busy_seen), 16'h0001);
    chk("oe_rel", 16'(oe), 16'h0000);
    busy_seen = 1'b0;
    a(tt, 1'b1, 1'b1, word, 1'b0, q);
    chk("second_word", q, word);
    chk("fetch_cnt2", 16'(n_fetch - f0), 16'h0001);
    chk("xfer_cnt", 16'(n_xfer - x0), 16'(tt == hph_pkg::ACC_DATA_INC));
    chk("half2_busy", 16'(busy_seen), 16'(tt == hph_pkg::ACC_DATA_INC));
  endtask
  // Data write pair with a slow transfer, then reselect while it finishes
  task automatic t_data_write();
    logic [15:0] q;
    int x0;
    xdly = 40;
    x0 = n_xfer;
    a(hph_pkg::ACC_DATA, 1'b0, 1'b0, 16'h0f0f, 1'b0, q);
    chk("xfer_half1", 16'(n_xfer - x0), 16'h0000);
    a(hph_pkg::ACC_DATA, 1'b0, 1'b1, 16'ha5c3, 1'b0, q);
    chk("wr_word2", wr_data, 16'ha5c3);
    chk("xfer_half2", 16'(n_xfer - x0), 16'h0001);
    // Let the deselect pull ready low first, so only the reselect can set the flag
    repeat (4) @(posedge clk_sys);
    busy_seen = 1'b0;
    a(hph_pkg::ACC_CTRL, 1'b1, 1'b0, 16'h0000, 1'b0, q);
    chk("reselect_busy", 16'(busy_seen), 16'h0001);
    xdly = 3;
  endtask
  // Address strobe: selects moved after its fall must not be taken
  task automatic t_addr_strobe();
    logic [15:0] q;
    a(hph_pkg::ACC_ADDR, 1'b0, 1'b0, 16'h7e81, 1'b1, q);
    chk("as_type", 16'(cur_t), 16'(hph_pkg::ACC_ADDR));
    chk("as_wr", wr_data, 16'h7e81);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_plain();
    t_data_read(hph_pkg::ACC_DATA);
    t_data_read(hph_pkg::ACC_DATA_INC);
    t_data_write();
    t_addr_strobe();
    repeat (10) @(posedge clk_sys);
    test_done();
  end
endmodule // tb_host_port_handshake
`default_nettype wire
